// file: adc_scan_cfg.svh
// Offsets, field positions and reset values of the scan, range and digital I/O registers
`ifndef ADC_SCAN_CFG_SVH
`define ADC_SCAN_CFG_SVH

// ------------------------------------------------------------------
// Bus geometry
// ------------------------------------------------------------------
`define ADDR_W          6
`define DATA_W          32

// ------------------------------------------------------------------
// Register indices (byte address is four times the index)
// ------------------------------------------------------------------
`define IDX_TRIG_RESLO  4'h0
`define IDX_RANGE_RESHI 4'h1
`define IDX_SCAN        4'h2
`define IDX_DIO_LO      4'h3
`define IDX_TRIG_SRC    4'h9
`define IDX_DIO_HI      4'hB

// ------------------------------------------------------------------
// Field positions and widths
// ------------------------------------------------------------------
`define CH_W            4
`define RANGE_W         4
`define NUM_CH          16
`define DIO_W           16
`define ADC_W           12
`define START_LSB       0
`define STOP_LSB        4
`define TRIG_SRC_W      2

// ------------------------------------------------------------------
// Range code limits per gain variant
// ------------------------------------------------------------------
`define STD_RANGE_MAX   4'h8
`define HIGH_RANGE_MAX  4'hB
`define REDUCED_MASK    4'h3

// ------------------------------------------------------------------
// Reset values and bus responses
// ------------------------------------------------------------------
`define CH_RESET        4'h0
`define RANGE_RESET     4'h0
`define TRIG_SRC_RESET  2'h0
`define DOUT_RESET      16'h0000
`define RESP_OKAY       2'h0
`define RESP_SLVERR     2'h2

`endif

// file: adc_scan_pkg.sv
// Types shared by the scan, range and digital I/O register block
package adc_scan_pkg;
    `include "adc_scan_cfg.svh"

    // Trigger sources selected by the two trigger-source bits
    typedef enum logic [1:0] {
        TRIG_SOFT,
        TRIG_EXT,
        TRIG_PACER
    } trig_src_e;

    // AXI4-Lite requests from the master
    typedef struct packed {
        logic                 awvalid;
        logic [`ADDR_W-1:0]   awaddr;
        logic                 wvalid;
        logic [`DATA_W-1:0]   wdata;
        logic [3:0]           wstrb;
        logic                 bready;
        logic                 arvalid;
        logic [`ADDR_W-1:0]   araddr;
        logic                 rready;
    } axi_req_s;

    // AXI4-Lite answers from the slave
    typedef struct packed {
        logic                 awready;
        logic                 wready;
        logic                 bvalid;
        logic [1:0]           bresp;
        logic                 arready;
        logic                 rvalid;
        logic [`DATA_W-1:0]   rdata;
        logic [1:0]           rresp;
    } axi_rsp_s;

    // Conversion result: data bits with channel tag
    typedef struct packed {
        logic [`ADC_W-1:0]    data;
        logic [`CH_W-1:0]     channel;
    } conv_result_s;
endpackage

// file: adc_scan_range_dio_regs.sv
// Scan sequencer, per-channel range store and digital I/O behind AXI4-Lite
//
// The AXI4-Lite interface to the registers was decided locally.
`timescale 1ns/1ps
`include "adc_scan_cfg.svh"

module adc_scan_range_dio_regs #(
    parameter bit HIGH_GAIN     = 1'b0,   // Selects high-gain range table
    parameter bit REDUCED_RANGE = 1'b0    // Only two range bits used
) (
    input  wire logic                        clk_sys,
    input  wire logic                        reset_n,
    input  wire adc_scan_pkg::axi_req_s      axi_req,
    output adc_scan_pkg::axi_rsp_s           axi_rsp,
    input  wire logic                        conv_trigger,
    input  wire logic                        conv_done,
    input  wire logic [`ADC_W-1:0]           conv_data,
    input  wire logic [`DIO_W-1:0]           digital_in_bits,
    output logic [`DIO_W-1:0]                digital_out_bits,
    output logic                             sw_trigger,
    output logic [`CH_W-1:0]                 current_channel,
    output logic [`RANGE_W-1:0]              range_code,
    output logic                             range_valid,
    output adc_scan_pkg::conv_result_s       conv_result
);
    import adc_scan_pkg::*;

    // ------------------------------------------------------------------
    // Functions
    // ------------------------------------------------------------------

    // Word-aligned hit on a register index
    function automatic logic reg_hit(input logic [`ADDR_W-1:0] addr,
                                     input logic [3:0] idx);
        reg_hit = (addr[1:0] == 2'h0) && (addr[`ADDR_W-1:2] == idx);
    endfunction

    // Trigger source from the two select bits
    function automatic trig_src_e trig_decode(input logic [`TRIG_SRC_W-1:0] st);
        // Bit zero ignored while bit one is clear
        if (!st[1]) begin
            trig_decode = TRIG_SOFT;
        end else if (!st[0]) begin
            trig_decode = TRIG_EXT;
        end else begin
            trig_decode = TRIG_PACER;
        end
    endfunction

    // ------------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------------
    // Write capture
    logic                      aw_hold_q;       // Write address captured
    logic [`ADDR_W-1:0]        awaddr_q;        // Captured write address
    logic                      w_hold_q;        // Write data captured
    logic [7:0]                wbyte_q;         // Captured low byte lane
    logic                      wlane_q;         // Low byte lane enabled

    // Responses
    logic                      bvalid_q;        // Write response pending
    logic [1:0]                bresp_q;         // Write response code
    logic                      rvalid_q;        // Read data pending
    logic [`DATA_W-1:0]        rdata_q;         // Read data word
    logic [1:0]                rresp_q;         // Read response code

    // Scan state
    logic [`CH_W-1:0]          start_q;         // Scan start channel
    logic [`CH_W-1:0]          stop_q;          // Scan stop channel
    logic [`CH_W-1:0]          cur_q;           // Current mux channel
    logic [`CH_W-1:0]          conv_ch_q;       // Channel of conversion in flight

    // Ranges
    logic [`RANGE_W-1:0]       range_q [`NUM_CH]; // Per-channel range store
    logic [`TRIG_SRC_W-1:0]    trig_src_q;      // Trigger source select

    // Digital I/O
    logic [`DIO_W-1:0]         dout_q;          // Latched digital outputs
    logic [`DIO_W-1:0]         din_meta_q;      // Input synchroniser, stage one
    logic [`DIO_W-1:0]         din_q;           // Input synchroniser, stage two

    // Triggers
    logic                      sw_trig_q;       // Registered software trigger
    conv_result_s              result_q;        // Last tagged result

    // ------------------------------------------------------------------
    // Bus decode
    // ------------------------------------------------------------------
    wire aw_take   = axi_req.awvalid && !aw_hold_q;
    wire w_take    = axi_req.wvalid && !w_hold_q;

    wire wr_go     = aw_hold_q && w_hold_q && !bvalid_q;

    // One read in flight
    wire ar_take   = axi_req.arvalid && !rvalid_q;

    wire wr_lane   = wr_go && wlane_q;


    // Write decode
    wire wr_hit_trig  = reg_hit(awaddr_q, `IDX_TRIG_RESLO);
    wire wr_hit_range = reg_hit(awaddr_q, `IDX_RANGE_RESHI);
    wire wr_hit_scan  = reg_hit(awaddr_q, `IDX_SCAN);
    wire wr_hit_dlo   = reg_hit(awaddr_q, `IDX_DIO_LO);
    wire wr_hit_dhi   = reg_hit(awaddr_q, `IDX_DIO_HI);
    wire wr_hit_src   = reg_hit(awaddr_q, `IDX_TRIG_SRC);
    wire wr_mapped    = wr_hit_trig | wr_hit_range | wr_hit_scan |
                        wr_hit_dlo | wr_hit_dhi | wr_hit_src;

    // Read decode
    wire rd_hit_reslo = reg_hit(axi_req.araddr, `IDX_TRIG_RESLO);
    wire rd_hit_reshi = reg_hit(axi_req.araddr, `IDX_RANGE_RESHI);
    wire rd_hit_scan  = reg_hit(axi_req.araddr, `IDX_SCAN);
    wire rd_hit_dlo   = reg_hit(axi_req.araddr, `IDX_DIO_LO);
    wire rd_hit_dhi   = reg_hit(axi_req.araddr, `IDX_DIO_HI);
    wire rd_hit_src   = reg_hit(axi_req.araddr, `IDX_TRIG_SRC);
    wire rd_mapped    = rd_hit_reslo | rd_hit_reshi | rd_hit_scan |
                        rd_hit_dlo | rd_hit_dhi | rd_hit_src;

    // Register writes; the byte sits in lane zero
    wire wr_scan  = wr_lane && wr_hit_scan;
    wire wr_range = wr_lane && wr_hit_range;
    wire wr_src   = wr_lane && wr_hit_src;
    wire wr_dlo   = wr_lane && wr_hit_dlo;
    wire wr_dhi   = wr_lane && wr_hit_dhi;


    // ------------------------------------------------------------------
    // Scan sequencer
    // ------------------------------------------------------------------
    wire trig_soft  = trig_decode(trig_src_q) == TRIG_SOFT;
    // Any value written to the trigger offset fires while the soft source is chosen, strobes ignored
    wire sw_fire    = wr_go && wr_hit_trig && trig_soft;

    // Outside triggers count only when a hardware source is chosen
    wire trig_fire  = sw_fire || (conv_trigger && !trig_soft);
    // Wrap to start after stop; a start above stop rolls through 15 to 0
    wire [`CH_W-1:0] ch_next = (cur_q == stop_q) ? start_q
                                                 : cur_q + 4'h1;

    // Scan limit fields
    wire [`CH_W-1:0] new_start = wbyte_q[`START_LSB +: `CH_W];
    wire [`CH_W-1:0] new_stop  = wbyte_q[`STOP_LSB +: `CH_W];
    // Reduced variant stores only the two low bits
    wire [`RANGE_W-1:0] range_wr = REDUCED_RANGE
                                 ? (wbyte_q[`RANGE_W-1:0] & `REDUCED_MASK)
                                 : wbyte_q[`RANGE_W-1:0];

    // Top usable code
    wire [`RANGE_W-1:0] range_max = HIGH_GAIN ? `HIGH_RANGE_MAX
                                              : `STD_RANGE_MAX;

    // ------------------------------------------------------------------
    // Read data selection
    // ------------------------------------------------------------------
    // Unmapped reads give zero
    wire [7:0] rd_byte =
        rd_hit_reslo ? {result_q.data[3:0], result_q.channel} :
        rd_hit_reshi ? result_q.data[`ADC_W-1:4] :
        rd_hit_scan  ? {4'h0, cur_q} :
        rd_hit_dlo   ? din_q[7:0] :
        rd_hit_dhi   ? din_q[15:8] :
        rd_hit_src   ? {6'h00, trig_src_q} :
                       8'h00;

    // ------------------------------------------------------------------
    // Write address and data capture, either order
    // ------------------------------------------------------------------
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            aw_hold_q <= 1'b0;
            awaddr_q  <= '0;
            w_hold_q  <= 1'b0;
            wbyte_q   <= 8'h00;
            wlane_q   <= 1'b0;
        end else begin
            // Holds drop once the write is performed
            aw_hold_q <= wr_go ? 1'b0 : (aw_hold_q | aw_take);
            w_hold_q  <= wr_go ? 1'b0 : (w_hold_q | w_take);

            if (aw_take) begin
                awaddr_q <= axi_req.awaddr;
            end

            if (w_take) begin
                wbyte_q <= axi_req.wdata[7:0];
                wlane_q <= axi_req.wstrb[0];
            end
        end
    end

    // ------------------------------------------------------------------
    // Write response
    // ------------------------------------------------------------------
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            bvalid_q <= 1'b0;
            // Idle reads okay
            bresp_q  <= `RESP_OKAY;
        end else if (wr_go) begin
            bvalid_q <= 1'b1;
            bresp_q  <= wr_mapped ? `RESP_OKAY : `RESP_SLVERR;

        end else if (axi_req.bready) begin
            // Taken by master
            bvalid_q <= 1'b0;
        end
    end

    // ------------------------------------------------------------------
    // Read channel; inputs are sampled at the accepting edge only
    // ------------------------------------------------------------------
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            rvalid_q <= 1'b0;
            rdata_q  <= '0;
            rresp_q  <= `RESP_OKAY;
        end else if (ar_take) begin
            rvalid_q <= 1'b1;
            rdata_q  <= {24'h000000, rd_byte};
            rresp_q  <= rd_mapped ? `RESP_OKAY : `RESP_SLVERR;

        end else if (axi_req.rready) begin
            // Taken by master
            rvalid_q <= 1'b0;
        end
    end

    // ------------------------------------------------------------------
    // Scan limits and current channel
    // ------------------------------------------------------------------
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            // All at channel zero
            start_q <= `CH_RESET;
            stop_q  <= `CH_RESET;
            cur_q   <= `CH_RESET;
        end else if (wr_scan) begin
            // A scan write beats a trigger in the same cycle
            start_q <= new_start;
            stop_q  <= new_stop;
            cur_q   <= new_start;

        end else if (trig_fire) begin
            // Step or wrap
            cur_q   <= ch_next;
        end
    end

    // ------------------------------------------------------------------
    // Per-channel range store, addressed by the start channel
    // ------------------------------------------------------------------
    generate
        // One entry per channel
        for (genvar ch = 0; ch < `NUM_CH; ch++) begin : g_range
            always_ff @(posedge clk_sys or negedge reset_n) begin
                if (!reset_n) begin
                    range_q[ch] <= `RANGE_RESET;
                end else if (wr_range && (start_q == ch[`CH_W-1:0])) begin
                    range_q[ch] <= range_wr;
                end
            end
        end
    endgenerate

    // ------------------------------------------------------------------
    // Trigger source select and software trigger pulse
    // ------------------------------------------------------------------
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            trig_src_q <= `TRIG_SRC_RESET;
            sw_trig_q  <= 1'b0;
        end else begin
            sw_trig_q <= sw_fire;

            if (wr_src) begin
                trig_src_q <= wbyte_q[`TRIG_SRC_W-1:0];
            end
        end
    end

    // ------------------------------------------------------------------
    // Conversion result tagging
    // ------------------------------------------------------------------
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            conv_ch_q <= `CH_RESET;
            result_q  <= '0;
        end else begin
            // Remember the channel being converted before the mux moves on
            if (trig_fire) begin
                conv_ch_q <= cur_q;
            end

            // Data with its channel
            if (conv_done) begin
                result_q <= '{data: conv_data, channel: conv_ch_q};
            end
        end
    end

    // ------------------------------------------------------------------
    // Digital outputs, write only
    // ------------------------------------------------------------------
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            dout_q <= `DOUT_RESET;
        end else begin
            if (wr_dlo) begin
                dout_q[7:0]  <= wbyte_q;
            end

            if (wr_dhi) begin
                dout_q[15:8] <= wbyte_q;
            end
        end
    end

    // ------------------------------------------------------------------
    // Digital input synchroniser; pins are asynchronous
    // ------------------------------------------------------------------
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            din_meta_q <= '0;
            din_q      <= '0;
        end else begin
            // Stage one may be metastable
            din_meta_q <= digital_in_bits;
            din_q      <= din_meta_q;
        end
    end

    // ------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------
    // Ready falls while held
    assign axi_rsp.awready  = !aw_hold_q;
    assign axi_rsp.wready   = !w_hold_q;
    assign axi_rsp.bvalid   = bvalid_q;
    assign axi_rsp.bresp    = bresp_q;
    assign axi_rsp.arready  = !rvalid_q;
    assign axi_rsp.rvalid   = rvalid_q;
    assign axi_rsp.rdata    = rdata_q;
    assign axi_rsp.rresp    = rresp_q;

    // Block side
    assign digital_out_bits = dout_q;
    assign sw_trigger       = sw_trig_q;
    assign current_channel  = cur_q;

    // Range of the channel now on the mux; unavailable codes flagged
    assign range_code       = range_q[cur_q];
    assign range_valid      = range_q[cur_q] <= range_max;
    assign conv_result      = result_q;
endmodule

// file: adc_scan_range_dio_regs_monitor.sv
// Port-level concurrent checks for the scan, range and digital I/O register block
`timescale 1ns/1ps
`include "adc_scan_cfg.svh"
module scan_regs_monitor #(
    parameter bit HIGH_GAIN     = 1'b0,   // Matches the block's range table choice
    parameter bit REDUCED_RANGE = 1'b0    // Matches the two-bit range variant
) (
    input wire logic                        clk_sys,
    input wire logic                        reset_n,
    input wire adc_scan_pkg::axi_req_s      axi_req,
    input wire adc_scan_pkg::axi_rsp_s      axi_rsp,
    input wire logic                        conv_trigger,
    input wire logic                        conv_done,
    input wire logic [`ADC_W-1:0]           conv_data,
    input wire logic [`DIO_W-1:0]           digital_out_bits,
    input wire logic                        sw_trigger,
    input wire logic [`CH_W-1:0]            current_channel,
    input wire logic [`RANGE_W-1:0]         range_code,
    input wire logic                        range_valid,
    input wire adc_scan_pkg::conv_result_s  conv_result
);
    import adc_scan_pkg::*;
    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!reset_n);
    // Skips the first edge: outputs still hold their reset values just after release
    a_range_flag: assert property ($past(reset_n) |-> range_valid ==
        (range_code <= (HIGH_GAIN ? `HIGH_RANGE_MAX : `STD_RANGE_MAX)))
        else $error("range_valid disagrees with range_code");
    a_reduced_bits: assert property (range_code <= (REDUCED_RANGE ? 4'h3 : 4'hF))
        else $error("range_code uses unused bits");
    a_bresp_hold: assert property (axi_rsp.bvalid && !axi_req.bready |=>
        axi_rsp.bvalid && $stable(axi_rsp.bresp)) else $error("write response dropped");
    a_write_lat: assert property (axi_req.awvalid && axi_rsp.awready && axi_req.wvalid
        && axi_rsp.wready && !axi_rsp.bvalid |-> ##2 axi_rsp.bvalid)
        else $error("write response late");
    a_read_upper: assert property (axi_req.arvalid && axi_rsp.arready |=>
        axi_rsp.rvalid && axi_rsp.rdata[31:8] == 24'h000000) else $error("bad read answer");
    a_sw_pulse: assert property (sw_trigger |=> !sw_trigger)
        else $error("sw_trigger longer than one cycle");
    a_result_load: assert property (conv_done |=> conv_result.data == $past(conv_data))
        else $error("conversion data not captured");
    a_dout_cause: assert property (!$stable(digital_out_bits) |-> axi_rsp.bvalid)
        else $error("outputs changed without a write");
    a_chan_cause: assert property (!$stable(current_channel) |-> axi_rsp.bvalid
        || $past(conv_trigger) || $past(conv_trigger, 2)) else $error("channel moved alone");
endmodule

bind adc_scan_range_dio_regs scan_regs_monitor #(
    .HIGH_GAIN(HIGH_GAIN), .REDUCED_RANGE(REDUCED_RANGE)
) mon (
    .clk_sys(clk_sys), .reset_n(reset_n), .axi_req(axi_req), .axi_rsp(axi_rsp),
    .conv_trigger(conv_trigger), .conv_done(conv_done), .conv_data(conv_data),
    .digital_out_bits(digital_out_bits), .sw_trigger(sw_trigger),
    .current_channel(current_channel), .range_code(range_code),
    .range_valid(range_valid), .conv_result(conv_result)
);

// file: adc_unit_model.sv
// Behavioural converter unit facing the sequencer's trigger and result ports
`timescale 1ns/1ps
`include "adc_scan_cfg.svh"
module adc_unit_model (
    input  wire logic               clk_sys,
    input  wire logic               reset_n,
    input  wire logic               sw_trigger,
    input  wire logic               fire,        // Bench asks for a hardware trigger
    output logic                    conv_trigger,
    output logic                    conv_done,
    output logic [`ADC_W-1:0]       conv_data
);
    logic [2:0]        busy_q;   // Conversion in flight, three cycles long
    logic [`ADC_W-1:0] cnt_q;    // Numbers each result so the bench can tell them apart
    // Data is only valid with conv_done; otherwise it toggles so stale capture shows
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            conv_trigger <= 1'b0;
            busy_q       <= 3'h0;
            conv_done    <= 1'b0;
            cnt_q        <= 12'h000;
            conv_data    <= 12'h000;
        end else begin
            conv_trigger <= fire;
            busy_q       <= {busy_q[1:0], sw_trigger | conv_trigger};
            conv_done    <= busy_q[2];
            cnt_q        <= cnt_q + {11'h000, busy_q[2]};
            conv_data    <= busy_q[2] ? 12'hA00 + cnt_q : ~conv_data;
        end
    end
endmodule

// file: adc_scan_range_dio_regs_tb.sv
// Self-checking bench for the scan, range and digital I/O register block
`timescale 1ns/1ps
`include "adc_scan_cfg.svh"
module adc_scan_range_dio_regs_tb;
    import adc_scan_pkg::*;
    logic         clk_sys = 1'b0;
    logic         reset_n;
    axi_req_s     req;
    axi_rsp_s     rsp;
    logic         fire, conv_trigger, conv_done, sw_trigger, range_valid;
    logic [11:0]  conv_data;
    logic [15:0]  pins, digital_out_bits;
    logic [3:0]   current_channel, range_code;
    conv_result_s conv_result;
    int           error_cnt = 0;
    int           n_checks = 0;
    always #20 clk_sys = ~clk_sys;
    adc_scan_range_dio_regs uut (.clk_sys(clk_sys), .reset_n(reset_n), .axi_req(req),
        .axi_rsp(rsp), .conv_trigger(conv_trigger), .conv_done(conv_done),
        .conv_data(conv_data), .digital_in_bits(pins), .digital_out_bits(digital_out_bits),
        .sw_trigger(sw_trigger), .current_channel(current_channel),
        .range_code(range_code), .range_valid(range_valid), .conv_result(conv_result));
    adc_unit_model adc (.clk_sys(clk_sys), .reset_n(reset_n), .sw_trigger(sw_trigger),
        .fire(fire), .conv_trigger(conv_trigger), .conv_done(conv_done),
        .conv_data(conv_data));
    // ------------------------------------------------------------------
    // Bus and compare tasks
    // ------------------------------------------------------------------
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    // Address and data offered together; each released at its own handshake
    task automatic wr(input logic [5:0] a, input logic [7:0] d, output logic [1:0] r);
        bit aw, w;
        aw = 0;
        w = 0;
        @(posedge clk_sys);
        req.awvalid <= 1'b1; req.awaddr <= a; req.wvalid <= 1'b1;
        req.wdata <= {24'h000000, d}; req.wstrb <= 4'h1; req.bready <= 1'b1;
        while (!(aw && w)) begin
            @(posedge clk_sys);
            if (req.awvalid && rsp.awready === 1'b1) begin aw = 1; req.awvalid <= 1'b0; end
            if (req.wvalid && rsp.wready === 1'b1) begin w = 1; req.wvalid <= 1'b0; end
        end
        while (rsp.bvalid !== 1'b1) @(posedge clk_sys);
        r = rsp.bresp;
        req.bready <= 1'b0;
    endtask
    task automatic rd(input logic [5:0] a, output logic [7:0] d, output logic [1:0] r);
        @(posedge clk_sys);
        req.arvalid <= 1'b1; req.araddr <= a; req.rready <= 1'b1;
        do @(posedge clk_sys); while (rsp.arready !== 1'b1);
        req.arvalid <= 1'b0;
        do @(posedge clk_sys); while (rsp.rvalid !== 1'b1);
        d = rsp.rdata[7:0];
        r = rsp.rresp;
        req.rready <= 1'b0;
    endtask
    // ------------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------------
    task automatic t_reset;
        logic [7:0] d; logic [1:0] r;
        chk("dout_rst", digital_out_bits, 16'h0000);
        rd(6'h08, d, r);
        chk("scan_rst", {r, d}, 10'h000);
    endtask
    // Every channel gets a distinct code; upper data bits must be dropped
    task automatic t_range;
        logic [1:0] r;
        for (int c = 0; c < 16; c++) begin
            wr(6'h08, {4'hF, 4'(c)}, r);
            wr(6'h04, {4'hA, 4'(c) ^ 4'h5}, r);
        end
        for (int c = 0; c < 16; c++) begin
            wr(6'h08, {4'hF, 4'(c)}, r);
            chk("range", range_code, 4'(c) ^ 4'h5);
            chk("rng_ok", range_valid, (4'(c) ^ 4'h5) <= `STD_RANGE_MAX);
        end
        wr(6'h08, 8'h00, r);
    endtask
    // Software triggers walk 3..7 and wrap; each result carries its channel
    task automatic t_scan;
        logic [7:0] d; logic [1:0] r; logic [3:0] ch;
        wr(6'h08, 8'h73, r);
        chk("start", current_channel, 4'h3);
        ch = 4'h3;
        for (int i = 0; i < 7; i++) begin
            wr(6'h00, 8'h5A, r);
            repeat (6) @(posedge clk_sys);
            chk("tag", conv_result, {12'hA00 + 12'(i), ch});
            ch = (ch == 4'h7) ? 4'h3 : ch + 4'h1;
            rd(6'h08, d, r);
            chk("cur", d, {4'h0, ch});
        end
    endtask
    // External source: writes to the trigger offset must not step the scan
    task automatic t_hw;
        logic [1:0] r;
        wr(6'h24, 8'h02, r);
        wr(6'h08, 8'hFE, r);
        wr(6'h00, 8'h00, r);
        chk("no_sw", current_channel, 4'hE);
        for (int i = 0; i < 3; i++) begin
            @(posedge clk_sys);
            fire <= 1'b1;
            @(posedge clk_sys);
            fire <= 1'b0;
            repeat (4) @(posedge clk_sys);
            chk("hw", current_channel, i[0] ? 4'hE : 4'hF);
        end
        wr(6'h24, 8'h00, r);
    endtask
    // Reads at output offsets return live pins, never the latched outputs
    task automatic t_dio;
        logic [7:0] d; logic [1:0] r;
        wr(6'h0C, 8'hA5, r);
        wr(6'h2C, 8'h3C, r);
        chk("dout", digital_out_bits, 16'h3CA5);
        for (int i = 0; i < 2; i++) begin
            pins <= i[0] ? 16'h0FF0 : 16'h5AC3;
            repeat (4) @(posedge clk_sys);
            rd(6'h0C, d, r);
            chk("din_lo", d, i[0] ? 8'hF0 : 8'hC3);
            rd(6'h2C, d, r);
            chk("din_hi", d, i[0] ? 8'h0F : 8'h5A);
        end
    endtask
    task automatic t_bad;
        logic [7:0] d; logic [1:0] r;
        rd(6'h14, d, r);
        chk("bad_rd", {r, d}, {`RESP_SLVERR, 8'h00});
        wr(6'h14, 8'hFF, r);
        chk("bad_wr", r, `RESP_SLVERR);
    endtask
    // ------------------------------------------------------------------
    // Sequence, verdict and watchdog
    // ------------------------------------------------------------------
    task automatic close_out;
        $display("checks %0d errors %0d", n_checks, error_cnt);
        if (error_cnt == 0 && n_checks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    initial begin
        reset_n = 1'b0;
        req = '0;
        fire = 1'b0;
        pins = 16'h0000;
        repeat (16) @(posedge clk_sys);
        reset_n <= 1'b1;
        t_reset;
        t_range;
        t_scan;
        t_hw;
        t_dio;
        t_bad;
        close_out;
    end
    // Far longer than the whole sequence needs
    initial begin
        #800000;
        error_cnt++;
        close_out;
    end
endmodule
